/* hdl/cycle_stretch_unit.sv */
// cycle stretch unit: inserts stretch states between second and third bus states
// assumes a bus sequencer that raises a one-cycle start in the second state
// and moves to the third state in the cycle after stretch_state falls
`timescale 1ns/10ps

// How it works
// - stretch only cpu or transfer-controller cycles to off-chip addresses
// - stretch states sit after the second and before the third bus state
// - reset loads configuration with 0xf3: fixed mode, three states
// - standby leaves configuration untouched; only reset reloads it
// - bits 7..4 read as ones and ignore writes; bits 3..0 read/write
// - mode 00 fixed, 10 pin-extended, 11 pin-triggered
// - mode 01 inserts no stretch states at all
// - count field gives zero to three states; zero still allows pin extension
// - fixed mode ignores the pin and inserts exactly the count
// - pin-extended inserts the count then continues while pin low
// - pin-triggered inserts the count only when pin is low
// - pin-extended samples the pin in the last counted state (the second state when count is zero), holds until high
// - pin-triggered samples the pin once in the second state only
// - fixed mode frees the pin for general i/o; pin modes claim it
module cycle_stretch_unit
  import stretch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus sequencer side
  input wire stretch_pkg::cycle_req_t req,
  output logic stretch_state,
  output logic cycle_done,
  // stretch request pin, active low
  input wire logic stretch_req_n,
  output logic pin_is_stretch
);

  // ------------------------------------------------------------
  // state and sub-blocks
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_HOLD = 2'b11
  } seq_t;

  seq_t state_r;
  seq_t state_nxt;
  stretch_cfg_t cfg;
  stretch_mode_t mode_r;
  logic [1:0] left_r;
  logic [1:0] left_nxt;
  logic pin_low;
  logic pin_sync;
  logic stretch_nxt;
  logic done_nxt;
  logic [31:0] prdata_w;
  logic pslverr_w;
  logic qualify;

  stretch_cfg_reg u_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata_w),
    .pready(),
    .pslverr(pslverr_w),
    .cfg(cfg)
  );

  stretch_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(stretch_req_n),
    .pin_sync(pin_sync)
  );

  assign pin_low = !pin_sync;

  // on-chip module accesses never qualify
  assign qualify = req.start && req.off_chip && req.from_master;

  // decides whether the pin condition applies for a mode
  function automatic logic pin_mode(input stretch_mode_t m);
    pin_mode = (m == MODE_PIN_EXT) || (m == MODE_PIN_TRIG);
  endfunction : pin_mode

  // ------------------------------------------------------------
  // stretch sequencer
  // ------------------------------------------------------------
  // sampling at start is the single sample in the second state
  always_comb
  begin
    state_nxt = state_r;
    left_nxt = left_r;
    stretch_nxt = 1'b0;
    done_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (qualify) // stretching begins only after the second state
        begin
          case (cfg.mode) // mode field decode
            MODE_FIXED: // pin ignored
              left_nxt = cfg.count;
            MODE_PIN_EXT: // count first, pin may extend even from zero
              left_nxt = cfg.count;
            MODE_PIN_TRIG: // count only if pin low
              left_nxt = pin_low ? cfg.count : 2'b00;
            default: // mode 01 never stretches
              left_nxt = 2'b00;
          endcase
          if (left_nxt != 2'b00)
          begin
            state_nxt = ST_COUNT;
            stretch_nxt = 1'b1;
          end
          else if (cfg.mode == MODE_PIN_EXT && pin_low)
          begin
            state_nxt = ST_HOLD;
            stretch_nxt = 1'b1;
          end
          else
            done_nxt = 1'b1;
        end
      end
      ST_COUNT:
      begin
        left_nxt = left_r - 2'b01;
        if (left_nxt != 2'b00)
          stretch_nxt = 1'b1;
        else if (mode_r == MODE_PIN_EXT && pin_low) // keep going while low
        begin
          state_nxt = ST_HOLD;
          stretch_nxt = 1'b1;
        end
        else
        begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1; // third state follows
        end
      end
      ST_HOLD:
      begin
        // pin-triggered never reaches here, so only pin-extended reads the pin in stretch states
        if (pin_low)
          stretch_nxt = 1'b1;
        else
        begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      left_r <= 2'b00;
    end
    else
    begin
      state_r <= state_nxt;
      left_r <= left_nxt;
    end
  end

  // mode captured per cycle so mid-cycle writes do not disturb it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= MODE_FIXED;
    else if (state_r == ST_IDLE && qualify)
      mode_r <= cfg.mode;
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stretch_state <= 1'b0;
      cycle_done <= 1'b0;
    end
    else
    begin
      stretch_state <= stretch_nxt;
      cycle_done <= done_nxt;
    end
  end

  // pin function select follows the live mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_is_stretch <= 1'b0;
    else
      pin_is_stretch <= pin_mode(cfg.mode);
  end

  // apb answer registered for one-flop outputs; ready is high only in the cycle after a setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      prdata <= prdata_w;
      pslverr <= pslverr_w;
      pready <= psel && !penable; // answers in the cycle after setup
    end
  end

endmodule : cycle_stretch_unit

/* inc/stretch_pkg.sv */
// constants and carrier types for the bus cycle stretch unit
// assumes a 32-bit apb slave and an 8-bit configuration register
package stretch_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] CFG_OFFSET = 16'hfff8;
  localparam logic [7:0] CFG_RESET = 8'hf3;
  localparam logic [3:0] CFG_FIXED_ONES = 4'hf;
  localparam int MODE_HI_POS = 3;
  localparam int MODE_LO_POS = 2;
  localparam int COUNT_HI_POS = 1;
  localparam int COUNT_LO_POS = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 25;
  localparam int APB_WAIT_CYCLES = 0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FIXED = 2'b00,
    MODE_NONE = 2'b01,
    MODE_PIN_EXT = 2'b10,
    MODE_PIN_TRIG = 2'b11
  } stretch_mode_t;

  typedef struct packed {
    stretch_mode_t mode;
    logic [1:0] count;
  } stretch_cfg_t;

  // bus cycle request from the cpu or transfer controller sequencer
  typedef struct packed {
    logic start;
    logic off_chip;
    logic from_master;
  } cycle_req_t;

endpackage : stretch_pkg

/* hdl/stretch_sync.sv */
// two-flop synchroniser for the stretch request pin
// assumes the pin is asynchronous to pclk
`timescale 1ns/10ps
module stretch_sync
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and result
  input wire logic pin_in,
  output logic pin_sync
);

  logic meta_r;

  // the first stage is read only by the second; resets high as the pin idles high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule : stretch_sync

/* hdl/stretch_cfg_reg.sv */
// apb slave holding the stretch configuration register
// assumes a single 32-bit apb master on pclk
`timescale 1ns/10ps
module stretch_cfg_reg
  import stretch_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration out
  output stretch_pkg::stretch_cfg_t cfg
);

  logic [3:0] cfg_r;
  logic hit;

  assign hit = (paddr == CFG_OFFSET);
  assign cfg = stretch_cfg_t'(cfg_r);
  // zero wait state slave
  assign pready = 1'b1;
  // flagged in the setup cycle; the parent registers it into the access cycle
  assign pslverr = psel && !penable && !hit;

  // only a reset or an apb write loads the register; standby has no effect here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r <= CFG_RESET[3:0];
    else if (psel && penable && pwrite && hit && pstrb[0])
      cfg_r <= pwdata[3:0]; // upper nibble is not writable
  end

  // read data: upper nibble always ones, unmapped reads zero
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (hit)
      prdata = {24'h00_0000, CFG_FIXED_ONES, cfg_r};
  end

endmodule : stretch_cfg_reg

/* tb/stretch_properties.sv */
// port assertions for the stretch unit
// assumes a bind onto cycle_stretch_unit and full-word strobes
`timescale 1ns/10ps
module stretch_properties
  import stretch_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sequencer side
  input wire stretch_pkg::cycle_req_t req,
  input wire logic stretch_state,
  input wire logic cycle_done
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [3:0] cfg_r;
  logic [1:0] md_r;
  logic [7:0] ct_r, cnt_r;
  logic busy_r, go;
  assign go = req.start && req.off_chip && req.from_master && !busy_r;
  // shadow of the writable config bits
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_r <= 4'h3;
    else if (psel && penable && pwrite && paddr == CFG_OFFSET)
      cfg_r <= pwdata[3:0];
  // busy from start to done
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      busy_r <= 1'b0;
    else if (go || cycle_done)
      busy_r <= go;
  // settings frozen at start, so a mid-cycle write cannot skew the count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {md_r, ct_r, cnt_r} <= 18'h0_0000;
    else if (go)
      {md_r, ct_r, cnt_r} <= {cfg_r[3:2], 8'(cfg_r[1:0]), 8'h00};
    else
      cnt_r <= cnt_r + 8'(stretch_state);
  // port relations
  a_ready_next:
    assert property (psel && !penable |=> pready) else $error("no pready");
  a_read_word:
    assert property (pready && !pslverr && !pwrite |-> prdata == {28'h000_000f, cfg_r})
    else $error("bad readback");
  a_skip_local:
    assert property (req.start && !(req.off_chip && req.from_master) && !busy_r
      |=> !cycle_done && !stretch_state) else $error("local cycle stretched");
  a_inside_cycle:
    assert property (stretch_state |-> busy_r && !cycle_done) else $error("stray stretch");
  a_fixed_exact:
    assert property (cycle_done && md_r == 2'b00 |-> cnt_r == ct_r) else $error("bad count");
  a_none_zero:
    assert property (cycle_done && md_r == 2'b01 |-> cnt_r == 8'h00) else $error("stretched");
  a_ext_min:
    assert property (cycle_done && md_r == 2'b10 |-> cnt_r >= ct_r) else $error("too short");
  a_trig_count:
    assert property (cycle_done && md_r == 2'b11 |-> cnt_r == ct_r || cnt_r == 8'h00)
    else $error("bad trigger count");
  c_ext_long: cover property (cycle_done && md_r == 2'b10 && cnt_r > 8'h03);
  c_trig_hit: cover property (cycle_done && md_r == 2'b11 && cnt_r == 8'h03);
  c_unmapped: cover property (pready && pslverr);
endmodule : stretch_properties

/* tb/stretch_target.sv */
// slow external device: pulls the stretch request low for a while
// assumes a pull-up, so the released pin reads high
`timescale 1ns/10ps
module stretch_target
#(
  parameter int HOLD = 10
)
(
  // select from the bench, and the pin
  input wire logic pclk,
  input wire logic slow,
  output logic stretch_req_n
);
  int n;
  // release after HOLD cycles so a stuck request cannot stall the bus
  always_ff @(posedge pclk)
    n <= slow ? n + int'(n < HOLD) : 0;
  assign stretch_req_n = !(slow && n < HOLD);
endmodule : stretch_target

/* tb/tb_top.sv */
// self-checking bench for the cycle stretch unit
// assumes design, partner and checker files compiled first
`timescale 1ns/10ps
module tb_top;
  import stretch_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, stretch_state, cycle_done, stretch_req_n, pin_is_stretch;
  logic slow = 1'b0;
  cycle_req_t req = 3'h0;
  int failures = 0;
  int comparisons = 0;
  int n, x;
  // design and the slow device on its pin
  cycle_stretch_unit dut (.*);
  stretch_target far (.pclk(pclk), .slow(slow), .stretch_req_n(stretch_req_n));
  always #20 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // one apb transfer; on a read d is the expected data
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w)
      check(prdata, d);
    check({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one bus cycle; n is the stretch count, -1 when no done came
  task automatic bus(input logic [1:0] q, input logic pin);
    int s;
    slow <= 1'b0;
    @(posedge pclk);
    slow <= pin;
    repeat (4) @(posedge pclk);
    req <= {1'b1, q};
    @(posedge pclk);
    req <= 3'h0;
    s = 0;
    n = -1;
    repeat (30)
    begin
      @(posedge pclk);
      if (cycle_done === 1'b1 && n < 0)
        n = s;
      s += int'(stretch_state);
    end
  endtask : bus
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFFSET, 32'h0000_00f3, 1'b0);
    apb(1'b1, CFG_OFFSET, 32'hffff_ff00, 1'b0);
    apb(1'b1, 16'hfffc, 32'h0000_000f, 1'b1);
    apb(1'b0, 16'hfffc, 32'h0000_0000, 1'b1);
    apb(1'b0, CFG_OFFSET, 32'h0000_00f0, 1'b0);
    $display("register test done");
    // every mode and count, pin idle and pin held low
    for (int k = 0; k < 32; k++)
    begin
      apb(1'b1, CFG_OFFSET, 32'(k[4:1]), 1'b0);
      bus(2'b11, k[0]);
      x = (k[4:3] == 2'b01 || k[4:3] == 2'b11 && !k[0]) ? 0 : int'(k[2:1]);
      if (k[4:3] == 2'b10 && k[0])
        check(32'(n > int'(k[2:1])), 32'h0000_0001);
      else
        check(32'(n), 32'(x));
      check(32'(pin_is_stretch), 32'(k[4]));
    end
    $display("mode test done");
    apb(1'b1, CFG_OFFSET, 32'h0000_0003, 1'b0);
    bus(2'b01, 1'b0);
    check(32'(n), 32'hffff_ffff);
    bus(2'b10, 1'b0);
    check(32'(n), 32'hffff_ffff);
    bus(2'b11, 1'b0);
    check(32'(n), 32'h0000_0003);
    $display("qualify test done");
    // a write to pin-extended mode lands mid-count; the running cycle keeps fixed mode
    fork
      bus(2'b11, 1'b1);
      begin
        repeat (5) @(posedge pclk);
        apb(1'b1, CFG_OFFSET, 32'h0000_000b, 1'b0);
      end
    join
    check(32'(n), 32'h0000_0003);
    $display("latch test done");
    // a second reset in mid-run reloads the configuration
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFFSET, 32'h0000_00f3, 1'b0);
    $display("reset test done");
    end_of_test();
  end
  // watchdog: the full run needs well under 100 us
  initial
  begin
    #200us;
    failures++;
    end_of_test();
  end
endmodule : tb_top
bind cycle_stretch_unit stretch_properties chk (.*);
